// >>> common/gpm_params.svh
// Graphics port mode control: shared constants
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH

// =====================================================================
// Queue and translation sizing
`define GPM_Q_DEPTH 32
`define GPM_Q_SLACK 2
`define GPM_TLB_ENTRIES 10
`define GPM_APERTURE_PAGES 8

// =====================================================================
// Encodings
`define GPM_SBA_IDLE 8'hFF
`define GPM_GTT_BASE 8'h40
`define GPM_PRIO_CLEAR 4'hE

`endif

// >>> common/gpm_pkg.sv
// Graphics port mode control: shared types
package gpm_pkg;

  // =====================================================================
  // Commands on the request byte, upper nibble
  typedef enum logic [3:0] {
    GPM_CMD_READ_LO = 4'h0,
    GPM_CMD_READ_HI = 4'h1,
    GPM_CMD_WRITE_LO = 4'h4,
    GPM_CMD_WRITE_HI = 4'h5
  } gpm_cmd_t;

  typedef enum logic [1:0] {
    GPM_RATE_1X = 2'b00,
    GPM_RATE_2X = 2'b01,
    GPM_RATE_4X = 2'b10,
    GPM_RATE_8X = 2'b11
  } gpm_rate_t;

  typedef enum logic [1:0] {
    GPM_KIND_SBA = 2'b00,
    GPM_KIND_PIPE = 2'b01,
    GPM_KIND_FRAME = 2'b10
  } gpm_kind_t;

  typedef enum logic {
    GPM_WAIT_PG = 1'b0,
    GPM_LOCKED = 1'b1
  } gpm_mstate_t;

  typedef struct packed {
    logic coh;
    logic hit;
    gpm_kind_t kind;
    logic [3:0] cmd;
    logic [15:0] addr;
  } gpm_req_t;

endpackage : gpm_pkg

// >>> common/gpm_if.sv
// Graphics port link between card end and target end
`timescale 1ns/100ps
`default_nettype none

interface gpm_if;
  logic link_clk;
  logic det;
  logic gpar;
  gpm_pkg::gpm_rate_t rate;
  logic [7:0] sba;
  logic pipe;
  logic frame;
  logic [7:0] ad;
  logic qfull;
  logic [7:0] rsp_data;
  logic stb_a;
  logic stb_b;

  modport dev (
    input link_clk, det, gpar, rate, sba, pipe, frame, ad,
    output qfull, rsp_data, stb_a, stb_b
  );

  modport card (
    output link_clk, det, gpar, rate, sba, pipe, frame, ad,
    input qfull, rsp_data, stb_a, stb_b
  );
endinterface : gpm_if

`default_nettype wire

// >>> rtl/gpm_dev.sv
// Graphics port target end: mode latch, decode, translation, request queue
`timescale 1ns/100ps
`default_nettype none
`include "gpm_params.svh"

// Function
// - Request queue holds 32 outstanding entries
// - Two 10-entry associative buffers, both shared by reads and writes
// - Newer 4X/8X, legacy 1X/4X, never 2X
// - Control polarity high newer, low legacy
// - Newer accepts only low-priority commands
// - Strobe first/second newer, true/complement legacy
// - Newer mode requests over sideband or frame, never pipe
// - Coherency for frame; newer also outside aperture
// - Mode follows installed card, no software select
// - Mode picked at power-good, held until reset
// - Sideband idle ones legacy, zeros newer
// - Capture detect and port strap at power-good
// - Detect set forces port selected
// - Newer mode at 4X keeps newer features

// =====================================================================
// Three-stage synchroniser; output follows once stages two and three agree
module gpm_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire logic [W-1:0] differ = s2 ^ s3;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= (s3 & ~differ) | (q & differ);
    end
  end
endmodule : gpm_sync3

// =====================================================================
// Target end
module gpm_dev #(
  parameter int Q_DEPTH = `GPM_Q_DEPTH,
  parameter int TLB_ENTRIES = `GPM_TLB_ENTRIES,
  parameter int APERTURE_PAGES = `GPM_APERTURE_PAGES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic power_good_input,
  gpm_if.dev link,
  output logic q_valid,
  output gpm_pkg::gpm_req_t q_data,
  input wire logic q_ready,
  output logic mode_locked,
  output logic mode_new,
  output logic port_select_strap_bit,
  output logic rate_err,
  output logic cmd_err,
  output logic q_ovf
);
  localparam int AW = $clog2(Q_DEPTH);
  localparam int PW = AW + 1;
  localparam int TW = $clog2(TLB_ENTRIES);

  if (Q_DEPTH < 4 || (Q_DEPTH & (Q_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("Q_DEPTH must be a power of two of at least 4");
  end
  if (TLB_ENTRIES < 2 || APERTURE_PAGES < 1 || APERTURE_PAGES > 16) begin : g_bad_tlb
    $error("TLB_ENTRIES or APERTURE_PAGES out of range");
  end

  // =====================================================================
  // Mode latch on the link clock
  logic [2:0] pin_s;
  gpm_sync3 #(.W(3)) u_pin_sync (
    .clk(link.link_clk),
    .rstn(rstn),
    .d({power_good_input, link.det, link.gpar}),
    .q(pin_s)
  );

  gpm_pkg::gpm_mstate_t mstate;
  logic mode_new_l;
  logic port_sel_l;
  wire logic lock_now = (mstate == gpm_pkg::GPM_WAIT_PG) && pin_s[2];

  // Only the card's straps decide; nothing can reopen the latch short of reset
  always_ff @(posedge link.link_clk or negedge rstn) begin
    if (!rstn) begin
      mstate <= gpm_pkg::GPM_WAIT_PG;
      mode_new_l <= 1'b0;
      port_sel_l <= 1'b0;
    end else begin
      unique case (mstate)
        gpm_pkg::GPM_WAIT_PG: begin
          if (lock_now) begin
            mstate <= gpm_pkg::GPM_LOCKED;
            mode_new_l <= pin_s[1];
            port_sel_l <= pin_s[0] | pin_s[1];
          end
        end
        gpm_pkg::GPM_LOCKED: begin
          mstate <= gpm_pkg::GPM_LOCKED;
        end
      endcase
    end
  end

  // =====================================================================
  // Request decode, all steered by the one latched flag
  wire logic locked = (mstate == gpm_pkg::GPM_LOCKED);
  wire logic inv = ~mode_new_l;
  wire logic [7:0] sba_log = link.sba ^ {8{mode_new_l}};
  wire logic sba_act = locked && (sba_log != `GPM_SBA_IDLE);
  wire logic pipe_raw = locked && (link.pipe ^ inv);
  wire logic pipe_act = pipe_raw && !mode_new_l;
  wire logic frame_act = locked && (link.frame ^ inv);
  wire logic req_any = frame_act || sba_act || pipe_act;
  wire logic use_sba = sba_act && !frame_act;
  wire logic [1:0] kind = frame_act ? 2'b10 : (use_sba ? 2'b00 : 2'b01);
  wire logic [7:0] req_byte = use_sba ? sba_log : link.ad;
  wire logic [3:0] cmd = req_byte[7:4];
  wire logic [3:0] page = req_byte[3:0];
  wire logic cmd_lo = cmd == gpm_pkg::GPM_CMD_READ_LO || cmd == gpm_pkg::GPM_CMD_WRITE_LO;
  wire logic cmd_hi = cmd == gpm_pkg::GPM_CMD_READ_HI || cmd == gpm_pkg::GPM_CMD_WRITE_HI;
  wire logic cmd_ok = cmd_lo || (cmd_hi && !mode_new_l);
  wire logic agp_req = !frame_act;

  // =====================================================================
  // Two fully associative translation buffers, shared by reads and writes
  logic [3:0] tag_a [TLB_ENTRIES];
  logic [3:0] tag_b [TLB_ENTRIES];
  logic [TLB_ENTRIES-1:0] val_a;
  logic [TLB_ENTRIES-1:0] val_b;
  logic [TLB_ENTRIES-1:0] hit_a;
  logic [TLB_ENTRIES-1:0] hit_b;
  logic fill_sel;
  logic [TW-1:0] fill_ptr;

  always_comb begin
    for (int i = 0; i < TLB_ENTRIES; i++) begin
      hit_a[i] = val_a[i] && (tag_a[i] == page);
      hit_b[i] = val_b[i] && (tag_b[i] == page);
    end
  end

  wire logic tlb_hit = agp_req && ((|hit_a) || (|hit_b));
  logic q_full;
  logic q_afull;
  wire logic accept = req_any && cmd_ok && !q_full;
  wire logic fill = accept && agp_req && !tlb_hit;
  wire logic [TW-1:0] fill_ptr_inc = (fill_ptr == TW'(TLB_ENTRIES - 1)) ? '0 : fill_ptr + 1'b1;

  // Victims alternate between buffers; no eviction by age, simple round robin
  always_ff @(posedge link.link_clk or negedge rstn) begin
    if (!rstn) begin
      val_a <= '0;
      val_b <= '0;
      fill_sel <= 1'b0;
      fill_ptr <= '0;
    end else if (fill) begin
      fill_sel <= ~fill_sel;
      if (fill_sel) begin
        val_b[fill_ptr] <= 1'b1;
        fill_ptr <= fill_ptr_inc;
      end else begin
        val_a[fill_ptr] <= 1'b1;
      end
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (fill && fill_sel) begin
      tag_b[fill_ptr] <= page;
    end
    if (fill && !fill_sel) begin
      tag_a[fill_ptr] <= page;
    end
  end

  wire logic [15:0] xaddr = agp_req ? {`GPM_GTT_BASE, 4'h0, page} : {12'h000, page};
  wire logic outside = {28'h0000000, page} >= APERTURE_PAGES;
  gpm_pkg::gpm_req_t wr_ent;
  assign wr_ent.coh = frame_act || (mode_new_l && outside);
  assign wr_ent.hit = tlb_hit;
  assign wr_ent.kind = gpm_pkg::gpm_kind_t'(kind);
  assign wr_ent.cmd = cmd;
  assign wr_ent.addr = xaddr;

  // =====================================================================
  // Request queue, written on the link clock, drained on the system clock
  gpm_pkg::gpm_req_t mem [Q_DEPTH];
  logic [PW-1:0] wbin;
  logic [PW-1:0] wgray;
  logic [PW-1:0] rbin;
  logic [PW-1:0] rgray;
  logic [PW-1:0] rgray_l;
  logic [PW-1:0] wgray_s;
  logic [PW-1:0] rbin_l;

  gpm_sync3 #(.W(PW)) u_rptr_sync (
    .clk(link.link_clk),
    .rstn(rstn),
    .d(rgray),
    .q(rgray_l)
  );

  always_comb begin
    rbin_l[PW-1] = rgray_l[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      rbin_l[i] = rbin_l[i+1] ^ rgray_l[i];
    end
  end

  wire logic [PW-1:0] used = wbin - rbin_l;
  assign q_full = used == PW'(Q_DEPTH);
  // Back-pressure early: the card may already have two more requests in flight
  assign q_afull = used >= PW'(Q_DEPTH - `GPM_Q_SLACK);
  wire logic [PW-1:0] next_wbin = wbin + PW'(accept);

  wire logic rate_bad = locked && (mode_new_l ?
    !(link.rate == gpm_pkg::GPM_RATE_4X || link.rate == gpm_pkg::GPM_RATE_8X) :
    !(link.rate == gpm_pkg::GPM_RATE_1X || link.rate == gpm_pkg::GPM_RATE_4X));
  wire logic cmd_bad = (req_any && !cmd_ok) || (pipe_raw && mode_new_l);
  wire logic ovf_now = req_any && cmd_ok && q_full;
  wire logic next_stb_a = mode_new_l ? accept : (link.stb_a ^ accept);
  wire logic next_stb_b = mode_new_l ? link.stb_a : ~next_stb_a;

  logic rate_err_l;
  logic cmd_err_l;
  logic ovf_l;

  always_ff @(posedge link.link_clk or negedge rstn) begin
    if (!rstn) begin
      wbin <= '0;
      wgray <= '0;
      rate_err_l <= 1'b0;
      cmd_err_l <= 1'b0;
      ovf_l <= 1'b0;
      link.rsp_data <= 8'h00;
      link.stb_a <= 1'b0;
      link.stb_b <= 1'b0;
      link.qfull <= 1'b0;
    end else begin
      wbin <= next_wbin;
      wgray <= next_wbin ^ (next_wbin >> 1);
      rate_err_l <= rate_err_l | rate_bad;
      cmd_err_l <= cmd_err_l | cmd_bad;
      ovf_l <= ovf_l | ovf_now;
      if (accept) begin
        link.rsp_data <= xaddr[7:0];
      end
      link.stb_a <= next_stb_a;
      link.stb_b <= next_stb_b;
      link.qfull <= (q_afull || !locked) ^ inv;
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (accept) begin
      mem[wbin[AW-1:0]] <= wr_ent;
    end
  end

  gpm_sync3 #(.W(PW)) u_wptr_sync (
    .clk(clk_sys),
    .rstn(rstn),
    .d(wgray),
    .q(wgray_s)
  );

  // Head entry stays counted until taken, so the shown word is one of the 32
  wire logic take_q = q_valid && q_ready;
  wire logic [PW-1:0] next_rbin = rbin + PW'(take_q);
  wire logic [PW-1:0] next_rgray = next_rbin ^ (next_rbin >> 1);
  wire logic next_q_valid = next_rgray != wgray_s;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rbin <= '0;
      rgray <= '0;
      q_valid <= 1'b0;
      q_data <= '0;
    end else begin
      rbin <= next_rbin;
      rgray <= next_rgray;
      q_valid <= next_q_valid;
      q_data <= mem[next_rbin[AW-1:0]];
    end
  end

  // =====================================================================
  // Status levels into the system domain
  logic [5:0] stat_s;
  gpm_sync3 #(.W(6)) u_stat_sync (
    .clk(clk_sys),
    .rstn(rstn),
    .d({locked, mode_new_l, port_sel_l, rate_err_l, cmd_err_l, ovf_l}),
    .q(stat_s)
  );

  assign mode_locked = stat_s[5];
  assign mode_new = stat_s[4];
  assign port_select_strap_bit = stat_s[3];
  assign rate_err = stat_s[2];
  assign cmd_err = stat_s[1];
  assign q_ovf = stat_s[0];
endmodule : gpm_dev

`default_nettype wire

// >>> rtl/gpm_card.sv
// Graphics port card end: link clock source, straps and request launch
`timescale 1ns/100ps
`default_nettype none
`include "gpm_params.svh"

module gpm_card (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic card_new,
  input wire gpm_pkg::gpm_rate_t rate_sel,
  input wire logic req_valid,
  input wire gpm_pkg::gpm_kind_t req_kind,
  input wire logic [3:0] req_cmd,
  input wire logic [3:0] req_page,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  gpm_if.card link
);
  // =====================================================================
  // Link clock is clk_sys divided by two; launch while it is high
  logic lclk;
  logic prev_a;
  assign link.link_clk = lclk;

  wire logic inv = ~card_new;
  wire logic take = req_valid && req_ready;
  wire logic use_frame = req_kind == gpm_pkg::GPM_KIND_FRAME;
  wire logic use_pipe = (req_kind == gpm_pkg::GPM_KIND_PIPE) && !card_new;
  wire logic use_sba = !use_frame && !use_pipe;
  // High-priority codes fold onto their low-priority twins in newer mode
  wire logic [3:0] cmd_eff = card_new ? (req_cmd & `GPM_PRIO_CLEAR) : req_cmd;
  wire logic [7:0] beat = {cmd_eff, req_page};
  wire logic [7:0] sba_mask = {8{card_new}};
  wire gpm_pkg::gpm_rate_t rate_eff = card_new ?
    ((rate_sel == gpm_pkg::GPM_RATE_8X) ? gpm_pkg::GPM_RATE_8X : gpm_pkg::GPM_RATE_4X) :
    ((rate_sel == gpm_pkg::GPM_RATE_1X) ? gpm_pkg::GPM_RATE_1X : gpm_pkg::GPM_RATE_4X);
  wire logic full_now = link.qfull ^ inv;
  wire logic beat_seen = card_new ? link.stb_a :
    ((link.stb_a != prev_a) && (link.stb_b != link.stb_a));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lclk <= 1'b0;
      prev_a <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      link.det <= 1'b0;
      link.gpar <= 1'b1;
      link.rate <= gpm_pkg::GPM_RATE_1X;
      link.sba <= `GPM_SBA_IDLE;
      link.pipe <= 1'b1;
      link.frame <= 1'b1;
      link.ad <= 8'h00;
    end else begin
      lclk <= ~lclk;
      link.det <= card_new;
      link.gpar <= ~card_new;
      // Ready only for the launch cycle that follows a not-full sample
      req_ready <= !lclk && !full_now;
      rsp_valid <= !lclk && beat_seen;
      if (!lclk) begin
        prev_a <= link.stb_a;
      end
      if (!lclk && beat_seen) begin
        rsp_data <= link.rsp_data;
      end
      if (lclk) begin
        link.rate <= rate_eff;
        link.sba <= ((take && use_sba) ? beat : `GPM_SBA_IDLE) ^ sba_mask;
        link.pipe <= (take && use_pipe) ^ inv;
        link.frame <= (take && use_frame) ^ inv;
        link.ad <= take ? beat : 8'h00;
      end
    end
  end
endmodule : gpm_card

`default_nettype wire

// >>> tb/gpm_link_sva.sv
// Link checker for the graphics port mode control
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Link rule checks
module gpm_link_sva (
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic det,
  input wire logic gpar,
  input wire gpm_pkg::gpm_rate_t rate,
  input wire logic [7:0] sba,
  input wire logic pipe,
  input wire logic frame,
  input wire logic [7:0] ad,
  input wire logic qfull,
  input wire logic [7:0] rsp_data,
  input wire logic stb_a,
  input wire logic stb_b
);
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rstn);

  // Device mode latches some cycles after detect rises; wait it out
  logic [4:0] det_run;
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      det_run <= '0;
    end else if (!det) begin
      det_run <= '0;
    end else if (det_run != 5'h1F) begin
      det_run <= det_run + 5'h01;
    end
  end

  sequence s_leg_sba;
    !det && sba != 8'hFF;
  endsequence
  // Newer requests only show as a fresh, non-idle code
  sequence s_new_sba;
    det && $past(det) && $changed(sba) && sba != 8'h00;
  endsequence
  sequence s_new_frame;
    det && $past(det) && frame && !$past(frame);
  endsequence

  chk_no_double_rate: assert property (rate != gpm_pkg::GPM_RATE_2X)
    else $error("link rate at 2X");
  chk_legacy_rate_set: assert property (!det |-> rate != gpm_pkg::GPM_RATE_8X)
    else $error("8X rate in legacy mode");
  chk_legacy_stb_pair: assert property (!det && $changed(stb_a) |-> stb_b == !stb_a)
    else $error("legacy strobes not complementary");
  chk_new_stb_pair: assert property (det_run == 5'h1F |-> stb_b == $past(stb_a))
    else $error("second strobe not one cycle after first");
  chk_legacy_req_stb: assert property (s_leg_sba |=> $changed(stb_a))
    else $error("legacy sideband request without strobe");
  chk_legacy_rsp_page: assert property (s_leg_sba |=> rsp_data == {4'h0, $past(sba[3:0])})
    else $error("legacy translated byte wrong");
  chk_new_rsp_page: assert property (s_new_sba |=> rsp_data == {4'h0, ~$past(sba[3:0])})
    else $error("newer translated byte wrong");
  chk_new_low_prio: assert property (s_new_sba |-> sba[4])
    else $error("high priority command in newer mode");
  chk_new_frame_idle: assert property (s_new_frame |-> sba == 8'h00 && !pipe)
    else $error("sideband not idle during newer frame");
  chk_legacy_pipe_idle: assert property (!det && !pipe |-> sba == 8'hFF && frame)
    else $error("legacy pipe request with other lines active");
endmodule : gpm_link_sva

`default_nettype wire

// >>> tb/graphics_port_mode_control_test.sv
// Self-checking bench for the graphics port mode control
`timescale 1ns/100ps
`default_nettype none
`include "gpm_params.svh"

module graphics_port_mode_control_test;
  localparam int LIMIT = 20000;
  localparam logic [3:0] CMDS [4] = '{4'h0, 4'h1, 4'h4, 4'h5};
  logic clk_sys, rstn, power_good_input, card_new, req_valid, req_ready, rsp_valid, q_ready;
  gpm_pkg::gpm_rate_t rate_sel;
  gpm_pkg::gpm_kind_t req_kind;
  logic [3:0] req_cmd, req_page;
  logic [7:0] rsp_data;
  logic q_valid, mode_locked, mode_new, strap, rate_err, cmd_err, q_ovf, exp_new;
  gpm_pkg::gpm_req_t q_data, q_data_b;
  logic lclk_b, q_valid_b, q_ready_b, locked_b, new_b, strap_b, rate_err_b, cmd_err_b, q_ovf_b;
  int n_fail, comparisons, cycles, n_taken;

  gpm_if if_a();
  gpm_if if_b();
  assign if_b.link_clk = lclk_b;

  gpm_card i_gpm_card (.clk_sys(clk_sys), .rstn(rstn), .card_new(card_new), .rate_sel(rate_sel),
    .req_valid(req_valid), .req_kind(req_kind), .req_cmd(req_cmd), .req_page(req_page),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link(if_a.card));
  gpm_dev i_gpm_dev (.clk_sys(clk_sys), .rstn(rstn), .power_good_input(power_good_input),
    .link(if_a.dev), .q_valid(q_valid), .q_data(q_data), .q_ready(q_ready),
    .mode_locked(mode_locked), .mode_new(mode_new), .port_select_strap_bit(strap),
    .rate_err(rate_err), .cmd_err(cmd_err), .q_ovf(q_ovf));
  // Second target end faces the bench, which breaks link rules on purpose
  gpm_dev i_gpm_dev_b (.clk_sys(clk_sys), .rstn(rstn), .power_good_input(power_good_input),
    .link(if_b.dev), .q_valid(q_valid_b), .q_data(q_data_b), .q_ready(q_ready_b),
    .mode_locked(locked_b), .mode_new(new_b), .port_select_strap_bit(strap_b),
    .rate_err(rate_err_b), .cmd_err(cmd_err_b), .q_ovf(q_ovf_b));
  gpm_link_sva i_gpm_link_sva (.rstn(rstn), .link_clk(if_a.link_clk), .det(if_a.det),
    .gpar(if_a.gpar), .rate(if_a.rate), .sba(if_a.sba), .pipe(if_a.pipe), .frame(if_a.frame),
    .ad(if_a.ad), .qfull(if_a.qfull), .rsp_data(if_a.rsp_data), .stb_a(if_a.stb_a),
    .stb_b(if_a.stb_b));

  // =====================================================================
  // Clocks and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    lclk_b = 1'b0;
    forever #3 lclk_b = ~lclk_b;
  end
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  // =====================================================================
  // Tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask : chk_val

  // Frame requests skip translation, so their hit bit is not predicted
  task automatic chk_req(input gpm_pkg::gpm_req_t got, input gpm_pkg::gpm_req_t exp,
      input bit care_hit);
    if (!care_hit) exp.hit = got.hit;
    chk_val({8'h00, got}, {8'h00, exp});
  endtask : chk_req

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic power_up(input logic is_new);
    int k;
    rstn = 1'b0;
    power_good_input = 1'b0;
    card_new = is_new;
    exp_new = is_new;
    repeat (8) @(posedge clk_sys);
    #2 rstn = 1'b1;
    repeat (4) @(posedge clk_sys);
    #2 power_good_input = 1'b1;
    for (k = 0; k < 200 && mode_locked !== 1'b1; k++) @(posedge clk_sys);
    #2 chk_val(mode_locked, 1'b1);
  endtask : power_up

  task automatic xfer(input gpm_pkg::gpm_kind_t kind, input logic [3:0] cmd,
      input logic [3:0] page, input gpm_pkg::gpm_kind_t ekind, input logic [3:0] ecmd,
      input bit ehit, input bit care_hit);
    gpm_pkg::gpm_req_t e;
    int k;
    e.coh = (ekind == gpm_pkg::GPM_KIND_FRAME) || (exp_new && page >= `GPM_APERTURE_PAGES);
    e.hit = ehit;
    e.kind = ekind;
    e.cmd = ecmd;
    e.addr = (ekind == gpm_pkg::GPM_KIND_FRAME) ? {12'h000, page} : {`GPM_GTT_BASE, 4'h0, page};
    req_kind = kind;
    req_cmd = cmd;
    req_page = page;
    req_valid = 1'b1;
    k = 0;
    do begin @(negedge clk_sys); k++; end while (req_ready !== 1'b1 && k < 100);
    @(posedge clk_sys);
    #2 req_valid = 1'b0;
    k = 0;
    do begin @(negedge clk_sys); k++; end while (rsp_valid !== 1'b1 && k < 100);
    chk_val(rsp_data, {4'h0, page});
    k = 0;
    while (q_valid !== 1'b1 && k < 100) begin @(negedge clk_sys); k++; end
    chk_req(q_data, e, care_hit);
    @(posedge clk_sys);
    #2 q_ready = 1'b1;
    @(posedge clk_sys);
    #2 q_ready = 1'b0;
  endtask : xfer

  task automatic lsend(input logic [7:0] code);
    @(posedge lclk_b);
    #2 if_b.sba = code;
    @(posedge lclk_b);
    #2 if_b.sba = 8'h00;
  endtask : lsend

  // =====================================================================
  // Main sequence
  initial begin
    int i;
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    rate_sel = gpm_pkg::GPM_RATE_1X;
    req_valid = 1'b0;
    req_kind = gpm_pkg::GPM_KIND_SBA;
    req_cmd = 4'h0;
    req_page = 4'h0;
    q_ready = 1'b0;
    q_ready_b = 1'b0;
    if_b.det = 1'b1;
    if_b.gpar = 1'b0;
    if_b.rate = gpm_pkg::GPM_RATE_2X;
    if_b.sba = 8'h00;
    if_b.pipe = 1'b0;
    if_b.frame = 1'b0;
    if_b.ad = 8'h00;
    power_up(1'b0);
    chk_val({mode_new, strap, if_a.qfull}, 3'h3);
    for (i = 0; i < 20; i++) begin
      xfer(gpm_pkg::GPM_KIND_SBA, CMDS[i % 4], 4'(i % 10), gpm_pkg::GPM_KIND_SBA, CMDS[i % 4],
        i >= 10, 1'b1);
    end
    xfer(gpm_pkg::GPM_KIND_PIPE, 4'h1, 4'h9, gpm_pkg::GPM_KIND_PIPE, 4'h1, 1'b1, 1'b1);
    xfer(gpm_pkg::GPM_KIND_FRAME, 4'h4, 4'h9, gpm_pkg::GPM_KIND_FRAME, 4'h4, 1'b0, 1'b0);
    chk_val({if_a.rate, if_a.sba, rate_err, cmd_err, q_ovf}, {2'h0, 8'hFF, 3'h0});
    rate_sel = gpm_pkg::GPM_RATE_2X;
    power_up(1'b1);
    chk_val({mode_new, strap, if_a.qfull}, 3'h6);
    xfer(gpm_pkg::GPM_KIND_SBA, 4'h1, 4'h8, gpm_pkg::GPM_KIND_SBA, 4'h0, 1'b0, 1'b1);
    xfer(gpm_pkg::GPM_KIND_PIPE, 4'h5, 4'h7, gpm_pkg::GPM_KIND_SBA, 4'h4, 1'b0, 1'b1);
    xfer(gpm_pkg::GPM_KIND_FRAME, 4'h0, 4'h1, gpm_pkg::GPM_KIND_FRAME, 4'h0, 1'b0, 1'b0);
    xfer(gpm_pkg::GPM_KIND_SBA, 4'h0, 4'h8, gpm_pkg::GPM_KIND_SBA, 4'h0, 1'b1, 1'b1);
    chk_val({if_a.rate, if_a.sba, rate_err, cmd_err}, {gpm_pkg::GPM_RATE_4X, 8'h00, 2'h0});
    power_good_input = 1'b0;
    repeat (20) @(posedge clk_sys);
    #2 chk_val({mode_locked, mode_new}, 2'h3);
    chk_val({locked_b, new_b, strap_b, rate_err_b}, 4'hF);
    @(posedge lclk_b);
    #2 if_b.rate = gpm_pkg::GPM_RATE_8X;
    lsend(8'hEE);
    repeat (10) @(posedge clk_sys);
    #2 chk_val(cmd_err_b, 1'b1);
    for (i = 0; i < 32; i++) begin
      lsend(~{4'h4, 4'(i)});
    end
    repeat (10) @(posedge clk_sys);
    #2 chk_val({if_b.qfull, q_ovf_b}, 2'h2);
    lsend(8'hBF);
    repeat (10) @(posedge clk_sys);
    #2 chk_val(q_ovf_b, 1'b1);
    q_ready_b = 1'b1;
    n_taken = 0;
    repeat (200) begin
      @(negedge clk_sys);
      if (q_valid_b === 1'b1) n_taken++;
    end
    chk_val(n_taken, 32);
    conclude();
  end
endmodule : graphics_port_mode_control_test

`default_nettype wire
